/* verilog/rbpm_pkg.sv */
// constants for the reset configuration and bus pin routing block
package rbpm_pkg;
  // register access port
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam logic [15:0] BUS_SEL_OFFSET  = 16'h1C00;
  localparam logic [15:0] BOOT_SEL_OFFSET = 16'h1C5A;

  // bus selection register layout
  localparam int          SAMP_CLK_BIT    = 15;
  localparam int          PP_MODE_LSB     = 12;
  localparam int          PP_MODE_W       = 3;
  localparam int          SP1_MODE_LSB    = 10;
  localparam int          SP0_MODE_LSB    = 8;
  localparam int          SP_MODE_W       = 2;
  localparam int          ADDR_MODE_LSB   = 0;
  localparam int          ADDR_MODE_W     = 6;
  localparam logic [15:0] BUS_SEL_RESET   = 16'h103F;
  localparam logic [15:0] BUS_SEL_WMASK   = 16'hFF3F;

  // parallel port mode codes
  localparam logic [2:0]  PP_HOST         = 3'h0;
  localparam logic [2:0]  PP_SPI_GIO_UART = 3'h1;
  localparam logic [2:0]  PP_GIO          = 3'h2;
  localparam logic [2:0]  PP_SPI_I2S2ND   = 3'h3;
  localparam logic [2:0]  PP_I2S_UART     = 3'h4;
  localparam logic [2:0]  PP_SPI_UART     = 3'h5;
  localparam logic [2:0]  PP_MIXED        = 3'h6;
  localparam logic [2:0]  PP_RESERVED     = 3'h7;
  localparam int          PP_SEL_W        = 7;

  // serial port mode codes
  localparam logic [1:0]  SP1_CARD        = 2'h0;
  localparam logic [1:0]  SP1_MSPI        = 2'h1;
  localparam logic [1:0]  SP1_GIO         = 2'h2;
  localparam logic [1:0]  SP1_RESERVED    = 2'h3;
  localparam logic [1:0]  SP0_CARD        = 2'h0;
  localparam logic [1:0]  SP0_I2S_GIO     = 2'h1;
  localparam logic [1:0]  SP0_GIO         = 2'h2;
  localparam logic [1:0]  SP0_BSP         = 2'h3;

  // reset timing, in system clock cycles
  localparam logic [3:0]  BOOT_LATCH_CYCLES = 4'hA;
  localparam logic [1:0]  PIN_HIZ_CYCLES    = 2'h2;

  // address reach in bits
  localparam logic [4:0]  REACH_SHORT     = 5'd15;
  localparam logic [4:0]  REACH_FULL      = 5'd21;

  // boot latch states
  typedef enum logic [1:0] {
    RBPM_BL_WAIT = 2'h0,
    RBPM_BL_DONE = 2'h1
  } rbpm_bl_state_e;
endpackage : rbpm_pkg

/* verilog/rbpm_boot_latch.sv */
// boot selection capture a fixed time after reset release
`timescale 1ns/100ps
module rbpm_boot_latch
#(
  parameter int W = 6
)
(
  // clock and internal reset
  input  wire logic         i_clk,
  input  wire logic         i_int_rst_n,
  // upper address pin levels
  input  wire logic [W-1:0] i_pins,
  // latched selection
  output logic      [W-1:0] o_boot_sel,
  output logic              o_valid
);
  rbpm_pkg::rbpm_bl_state_e state;
  rbpm_pkg::rbpm_bl_state_e next_state;
  logic [3:0]               cnt;
  logic [3:0]               next_cnt;
  logic [W-1:0]             next_boot_sel;

  // count from release, capture once, then freeze until next reset
  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_boot_sel = o_boot_sel;
    case (state)
      rbpm_pkg::RBPM_BL_WAIT:
      begin
        next_cnt = cnt + 4'h1;
        if (next_cnt == rbpm_pkg::BOOT_LATCH_CYCLES)
        begin
          next_boot_sel = i_pins;
          next_state    = rbpm_pkg::RBPM_BL_DONE;
        end
      end
      rbpm_pkg::RBPM_BL_DONE:
        next_state = rbpm_pkg::RBPM_BL_DONE;
      default:
        next_state = rbpm_pkg::RBPM_BL_WAIT;
    endcase
  end

  // state registers
  always_ff @(posedge i_clk)
  begin
    if (!i_int_rst_n)
    begin
      state      <= rbpm_pkg::RBPM_BL_WAIT;
      cnt        <= 4'h0;
      o_boot_sel <= '0;
    end
    else
    begin
      state      <= next_state;
      cnt        <= next_cnt;
      o_boot_sel <= next_boot_sel;
    end
  end

  assign o_valid = (state == rbpm_pkg::RBPM_BL_DONE);

  a_latch_at_ten: assert property (@(posedge i_clk)
    disable iff (!i_int_rst_n)
    $rose(i_int_rst_n) |-> !o_valid [*8] ##1 !o_valid [*2] ##1 o_valid)
    else $error("boot selection not latched ten cycles after release");

  a_latch_holds: assert property (@(posedge i_clk)
    disable iff (!i_int_rst_n)
    $past(o_valid) |-> $stable(o_boot_sel))
    else $error("boot selection changed after it was latched");
endmodule : rbpm_boot_latch

/* verilog/rbpm_port_router.sv */
// decode of the bus selection fields into peripheral pin owners
`timescale 1ns/100ps
module rbpm_port_router
(
  // mode fields
  input  wire logic [2:0] i_pp_mode,
  input  wire logic [1:0] i_sp1_mode,
  input  wire logic [1:0] i_sp0_mode,
  input  wire logic       i_samp_clk_sel,
  // one-hot pin owners, all zero for a reserved code
  output logic      [6:0] o_pp_sel,
  output logic      [2:0] o_sp1_sel,
  output logic      [3:0] o_sp0_sel,
  output logic            o_sp0_last_samp
);
  // one-hot of a code, empty when the code is at or past the limit
  function automatic logic [7:0] onehot(input logic [2:0] code,
                                         input logic [3:0] limit);
    logic [7:0] v;
    v = 8'h00;
    if ({1'b0, code} < limit)
      v[code] = 1'b1;
    return v;
  endfunction : onehot

  logic [7:0] pp_hot;
  logic [7:0] sp1_hot;
  logic [7:0] sp0_hot;

  // reserved codes leave the pins with no owner
  always_comb
  begin
    pp_hot    = onehot(i_pp_mode, 4'h7);
    sp1_hot   = onehot({1'b0, i_sp1_mode}, 4'h3);
    sp0_hot   = onehot({1'b0, i_sp0_mode}, 4'h4);
    o_pp_sel  = pp_hot[6:0];
    o_sp1_sel = sp1_hot[2:0];
    o_sp0_sel = sp0_hot[3:0];
    o_sp0_last_samp = i_samp_clk_sel &
                      (i_sp0_mode == rbpm_pkg::SP0_BSP);
  end
endmodule : rbpm_port_router

/* verilog/rbpm_top.sv */
// reset straps, boot selection latch and bus pin routing register
//
// How it works
// - strap low: regulator on, reset ANDs supply good
// - strap high: regulator off, pin-only reset
// - clock select low: USB oscillator, USB regulator
// - clock select high: external clock, USB parts off in reset, then under software enable
// - upper address pins start as GPIO inputs
// - pins latched ten cycles after reset release
// - boot program reads latched boot selection
// - address output mode set by register write
// - address mode widens reach 15 to 21
// - NAND and SDRAM boots need no switch
// - routing changes the cycle after write
// - mode bit 1 GPIO, 0 address output
// - bit 15 picks clock on last port-0 pin, only with port 0 in BSP mode
// - parallel mode field resets 001, 111 reserved
// - parallel codes 001 to 011 routings
// - parallel codes 100 to 110 routings
// - serial port 1 field resets 00
// - serial port 0 field resets 00
// - bits 7 and 6 read zero
`timescale 1ns/100ps
module rbpm_top
#(
  parameter int PINS = 6
)
(
  // clock and reset pin
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // straps and supply monitor
  input  wire logic              i_core_regulator_enable_strap,
  input  wire logic              i_clock_source_select_strap,
  input  wire logic              i_supply_good,
  input  wire logic              i_usb_osc_sw_enable,
  input  wire logic              i_usb_regulator_sw_enable,
  // I/O space register port
  input  wire logic [15:0]       i_io_addr,
  input  wire logic              i_io_wr,
  input  wire logic              i_io_rd,
  input  wire logic [15:0]       i_io_wdata,
  output logic      [15:0]       o_io_rdata,
  output logic                   o_io_rvalid,
  // upper external address pins
  input  wire logic [PINS-1:0]   i_ext_addr_pin_in,
  output logic      [PINS-1:0]   o_ext_addr_pin_out,
  output logic      [PINS-1:0]   o_ext_addr_pin_oe,
  // memory interface and general io sides of those pins
  input  wire logic [PINS-1:0]   i_external_memory_interface_addr_hi,
  input  wire logic [PINS-1:0]   i_gio_out,
  input  wire logic [PINS-1:0]   i_gio_oe,
  output logic      [PINS-1:0]   o_gio_in,
  // power and clock configuration
  output logic                   o_int_rst_n,
  output logic                   o_core_regulator_enable,
  output logic                   o_core_regulator_output_oe,
  output logic                   o_supply_good_eff,
  output logic                   o_sysclk_from_ext,
  output logic                   o_usb_osc_enable,
  output logic                   o_usb_regulator_enable,
  // pin routing
  output logic      [6:0]        o_pp_sel,
  output logic      [2:0]        o_sp1_sel,
  output logic      [3:0]        o_sp0_sel,
  output logic                   o_sp0_last_samp,
  output logic      [4:0]        o_addr_reach,
  output logic      [PINS-1:0]   o_boot_sel,
  output logic                   o_boot_valid
);
  logic            supply_good_eff;
  logic            int_rst_n;
  logic            ldo_strap;
  logic            clk_strap;
  logic            next_ldo_strap;
  logic            next_clk_strap;
  logic [15:0]     bus_sel;
  logic [15:0]     next_bus_sel;
  logic [1:0]      hiz_cnt;
  logic [1:0]      next_hiz_cnt;
  logic [6:0]      r_pp_sel;
  logic [2:0]      r_sp1_sel;
  logic [3:0]      r_sp0_sel;
  logic            r_sp0_last;
  logic [PINS-1:0] amode;
  logic [PINS-1:0] next_amode;
  logic [15:0]     next_rdata;
  logic            bus_wr;
  logic            boot_rd;
  logic [PINS-1:0] boot_sel;
  logic            boot_valid;

  // strap high bypasses the monitor, so only the pin resets
  always_comb
  begin
    supply_good_eff = i_core_regulator_enable_strap | i_supply_good;
    int_rst_n       = i_rst_n & supply_good_eff;
  end

  // straps are caught every cycle in reset and frozen after release
  always_comb
  begin
    next_ldo_strap = int_rst_n ? ldo_strap : i_core_regulator_enable_strap;
    next_clk_strap = int_rst_n ? clk_strap : i_clock_source_select_strap;
  end

  always_ff @(posedge i_clk)
  begin
    ldo_strap <= next_ldo_strap;
    clk_strap <= next_clk_strap;
  end

  // power and clock source outputs, registered
  always_ff @(posedge i_clk)
  begin
    o_int_rst_n                <= int_rst_n;
    o_supply_good_eff          <= supply_good_eff;
    o_core_regulator_enable    <= !next_ldo_strap;
    o_core_regulator_output_oe <= !next_ldo_strap;
    o_sysclk_from_ext          <= next_clk_strap;
    // strap low keeps the USB parts on; strap high leaves it to software
    o_usb_osc_enable           <= !next_clk_strap |
                                  (int_rst_n & i_usb_osc_sw_enable);
    o_usb_regulator_enable     <= !next_clk_strap |
                                  (int_rst_n & i_usb_regulator_sw_enable);
  end

  // register port decode
  always_comb
  begin
    bus_wr  = i_io_wr & (i_io_addr == rbpm_pkg::BUS_SEL_OFFSET);
    boot_rd = i_io_addr == rbpm_pkg::BOOT_SEL_OFFSET;
  end

  // reserved bits 7:6 never take a write
  always_comb
  begin
    next_bus_sel = bus_sel;
    if (bus_wr)
      next_bus_sel = i_io_wdata & rbpm_pkg::BUS_SEL_WMASK;
    next_amode = next_bus_sel[rbpm_pkg::ADDR_MODE_LSB +: PINS];
  end

  always_ff @(posedge i_clk)
  begin
    if (!int_rst_n)
      bus_sel <= rbpm_pkg::BUS_SEL_RESET;
    else
      bus_sel <= next_bus_sel;
  end

  // routing decoded from the incoming value, so it lands with the write
  rbpm_port_router u_router
  (
    .i_pp_mode      (next_bus_sel[rbpm_pkg::PP_MODE_LSB +: 3]),
    .i_sp1_mode     (next_bus_sel[rbpm_pkg::SP1_MODE_LSB +: 2]),
    .i_sp0_mode     (next_bus_sel[rbpm_pkg::SP0_MODE_LSB +: 2]),
    .i_samp_clk_sel (next_bus_sel[rbpm_pkg::SAMP_CLK_BIT]),
    .o_pp_sel       (r_pp_sel),
    .o_sp1_sel      (r_sp1_sel),
    .o_sp0_sel      (r_sp0_sel),
    .o_sp0_last_samp(r_sp0_last)
  );

  // registered routing; peripherals must be gated around a change
  always_ff @(posedge i_clk)
  begin
    if (!int_rst_n)
    begin
      o_pp_sel        <= 7'h02;
      o_sp1_sel       <= 3'h1;
      o_sp0_sel       <= 4'h1;
      o_sp0_last_samp <= 1'b0;
      amode           <= '1;
      o_addr_reach    <= rbpm_pkg::REACH_SHORT;
    end
    else
    begin
      o_pp_sel        <= r_pp_sel;
      o_sp1_sel       <= r_sp1_sel;
      o_sp0_sel       <= r_sp0_sel;
      o_sp0_last_samp <= r_sp0_last;
      amode           <= next_amode;
      // reach only widens once every upper pin is address; NAND and
      // SDRAM never need it
      o_addr_reach    <= (next_amode == '0) ? rbpm_pkg::REACH_FULL
                                            : rbpm_pkg::REACH_SHORT;
    end
  end

  // pins stay high impedance in reset and two cycles after it
  always_comb
  begin
    next_hiz_cnt = hiz_cnt;
    if (hiz_cnt != rbpm_pkg::PIN_HIZ_CYCLES)
      next_hiz_cnt = hiz_cnt + 2'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!int_rst_n)
      hiz_cnt <= 2'h0;
    else
      hiz_cnt <= next_hiz_cnt;
  end

  // per-pin mux: 1 gives general io, 0 drives the address bit
  always_ff @(posedge i_clk)
  begin
    if (!int_rst_n || next_hiz_cnt != rbpm_pkg::PIN_HIZ_CYCLES)
    begin
      o_ext_addr_pin_out <= '0;
      o_ext_addr_pin_oe  <= '0;
    end
    else
    begin
      for (int i = 0; i < PINS; i++)
      begin
        o_ext_addr_pin_out[i] <= next_amode[i] ? i_gio_out[i]
                                               : i_external_memory_interface_addr_hi[i];
        o_ext_addr_pin_oe[i]  <= next_amode[i] ? i_gio_oe[i]
                                               : 1'b1;
      end
    end
  end

  // general io input sees the pin only in io mode
  always_ff @(posedge i_clk)
  begin
    o_gio_in <= i_ext_addr_pin_in & next_amode;
  end

  rbpm_boot_latch #(.W(PINS)) u_boot
  (
    .i_clk      (i_clk),
    .i_int_rst_n(int_rst_n),
    .i_pins     (i_ext_addr_pin_in),
    .o_boot_sel (boot_sel),
    .o_valid    (boot_valid)
  );

  // boot selection readable for the boot program
  always_ff @(posedge i_clk)
  begin
    o_boot_sel   <= boot_sel;
    o_boot_valid <= boot_valid;
  end

  // read data, unmapped addresses answer zero
  always_comb
  begin
    next_rdata = 16'h0000;
    if (i_io_addr == rbpm_pkg::BUS_SEL_OFFSET)
      next_rdata = bus_sel & rbpm_pkg::BUS_SEL_WMASK;
    else if (boot_rd)
      next_rdata = {{(16-PINS){1'b0}}, boot_sel};
  end

  always_ff @(posedge i_clk)
  begin
    if (!int_rst_n)
    begin
      o_io_rdata  <= 16'h0000;
      o_io_rvalid <= 1'b0;
    end
    else
    begin
      o_io_rdata  <= i_io_rd ? next_rdata : 16'h0000;
      o_io_rvalid <= i_io_rd;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking

  a_reset_and_good: assert property (
    !ldo_strap && !i_supply_good |=> !o_int_rst_n)
    else $error("supply good low did not hold reset");

  a_bypass_monitor: assert property (
    i_core_regulator_enable_strap && i_rst_n |=> o_int_rst_n &&
      o_supply_good_eff)
    else $error("regulator bypass still used the supply monitor");

  a_regulator_off: assert property (
    disable iff (!int_rst_n)
    ldo_strap |=> !o_core_regulator_enable && !o_core_regulator_output_oe)
    else $error("regulator on with strap high");

  a_usb_forced_on: assert property (
    !clk_strap && !i_clock_source_select_strap |=>
      o_usb_regulator_enable && o_usb_osc_enable && !o_sysclk_from_ext)
    else $error("usb parts off with clock select low");

  a_usb_off_reset: assert property (
    !int_rst_n && i_clock_source_select_strap |=>
      !o_usb_regulator_enable && !o_usb_osc_enable && o_sysclk_from_ext)
    else $error("usb parts on in reset with clock select high");

  a_reset_values: assert property (
    $rose(int_rst_n) |-> bus_sel == rbpm_pkg::BUS_SEL_RESET &&
      o_ext_addr_pin_oe == '0 ##1 o_ext_addr_pin_oe == '0)
    else $error("bus selection reset value or pin float wrong");

  a_route_next_cycle: assert property (
    disable iff (!int_rst_n)
    bus_wr && i_io_wdata[14:12] == rbpm_pkg::PP_GIO |=>
      o_pp_sel == 7'h04)
    else $error("routing did not follow the write in one cycle");

  a_reserved_unowned: assert property (
    disable iff (!int_rst_n)
    bus_wr && i_io_wdata[14:12] == rbpm_pkg::PP_RESERVED |=>
      o_pp_sel == 7'h00)
    else $error("reserved parallel code still routed pins");

  a_reserved_zero: assert property (
    disable iff (!int_rst_n)
    i_io_rd && i_io_addr == rbpm_pkg::BUS_SEL_OFFSET |=>
      o_io_rvalid && o_io_rdata[7:6] == 2'b00)
    else $error("reserved bits did not read zero");

  a_address_drive: assert property (
    disable iff (!int_rst_n)
    hiz_cnt == rbpm_pkg::PIN_HIZ_CYCLES && bus_wr && i_io_wdata[0] == 1'b0
      |=> o_ext_addr_pin_oe[0] &&
        o_ext_addr_pin_out[0] == $past(i_external_memory_interface_addr_hi[0]))
    else $error("address mode pin not driven");
endmodule : rbpm_top

/* verif/rbpm_board.sv */
// board side model: straps, supply monitor and boot terminations
`timescale 1ns/100ps
module rbpm_board
(
  // bench settings and reset pin
  input  wire logic       i_rst_n,
  input  wire logic [1:0] i_strap_cfg,
  input  wire logic       i_pwr_ok,
  input  wire logic [5:0] i_boot_term,
  // device pin side
  input  wire logic [5:0] i_pin_out,
  input  wire logic [5:0] i_pin_oe,
  output logic      [1:0] o_straps,
  output logic            o_supply_good,
  output logic      [5:0] o_pin_lvl
);
  // straps follow the setting only while reset is held, never live
  always_latch
    if (!i_rst_n)
      o_straps = i_strap_cfg;
  // external supply case leans on the reset pin from the bench
  assign o_supply_good = i_pwr_ok;
  // passive terminations give way wherever the device drives
  assign o_pin_lvl = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_boot_term);
endmodule : rbpm_board

/* verif/reset_config_and_bus_pin_mux_tb.sv */
// self-checking bench for the reset straps and bus pin routing block
`timescale 1ns/100ps
module reset_config_and_bus_pin_mux_tb;
  logic        i_clk, rst_n, wr, rd, osc_sw, ldo_sw, pwr_ok;
  logic [15:0] addr, wdata, rdata;
  logic [5:0]  external_memory_interface_hi, gio_out, gio_oe, boot_term, pin_out, pin_oe;
  logic [5:0]  gio_in, pin_lvl, boot_sel;
  logic [1:0]  strap_cfg, straps;
  logic        rvalid, int_rst_n, reg_en, reg_oe, sg_eff, sg, from_ext;
  logic        usb_osc, usb_ldo, last_samp, boot_valid;
  logic [6:0]  pp_sel;
  logic [2:0]  sp1_sel;
  logic [3:0]  sp0_sel;
  logic [4:0]  reach;
  int          error_cnt, num_checks, cycles;

  rbpm_board board (.i_rst_n(rst_n), .i_strap_cfg(strap_cfg),
    .i_pwr_ok(pwr_ok), .i_boot_term(boot_term), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .o_straps(straps), .o_supply_good(sg),
    .o_pin_lvl(pin_lvl));

  rbpm_top dut (.i_clk(i_clk), .i_rst_n(rst_n),
    .i_core_regulator_enable_strap(straps[0]),
    .i_clock_source_select_strap(straps[1]), .i_supply_good(sg),
    .i_usb_osc_sw_enable(osc_sw), .i_usb_regulator_sw_enable(ldo_sw),
    .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata),
    .o_io_rdata(rdata), .o_io_rvalid(rvalid),
    .i_ext_addr_pin_in(pin_lvl), .o_ext_addr_pin_out(pin_out),
    .o_ext_addr_pin_oe(pin_oe), .i_external_memory_interface_addr_hi(external_memory_interface_hi),
    .i_gio_out(gio_out), .i_gio_oe(gio_oe), .o_gio_in(gio_in),
    .o_int_rst_n(int_rst_n), .o_core_regulator_enable(reg_en),
    .o_core_regulator_output_oe(reg_oe), .o_supply_good_eff(sg_eff),
    .o_sysclk_from_ext(from_ext), .o_usb_osc_enable(usb_osc),
    .o_usb_regulator_enable(usb_ldo), .o_pp_sel(pp_sel),
    .o_sp1_sel(sp1_sel), .o_sp0_sel(sp0_sel),
    .o_sp0_last_samp(last_samp), .o_addr_reach(reach),
    .o_boot_sel(boot_sel), .o_boot_valid(boot_valid));

  // free running system clock
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input logic [15:0] got, exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic summarize;
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // reset pin low for four cycles with new straps
  task automatic do_reset(input logic [1:0] s);
    @(negedge i_clk);
    rst_n = 1'b0;
    strap_cfg = s;
    repeat (4) @(negedge i_clk);
    rst_n = 1'b1;
  endtask : do_reset

  task automatic wr16(input logic [15:0] a, d);
    @(negedge i_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge i_clk);
    wr = 1'b0;
  endtask : wr16

  // read answer stands one cycle, so it is sampled at the next negedge
  task automatic rd16(input logic [15:0] a, exp);
    @(negedge i_clk);
    addr = a;
    rd = 1'b1;
    @(negedge i_clk);
    rd = 1'b0;
    chk(rvalid, 16'h0001, "read valid");
    chk(rdata, exp, "read data");
  endtask : rd16

  task automatic t_boot;
    boot_term = 6'h2D;
    do_reset(2'h3);
    @(posedge i_clk);
    #1 chk(pin_oe, 16'h0000, "pins float");
    repeat (8) @(posedge i_clk);
    #1 chk(boot_valid, 16'h0000, "early latch");
    repeat (4) @(posedge i_clk);
    #1 chk(boot_valid, 16'h0001, "latch valid");
    chk(boot_sel, 16'h002D, "boot code");
    rd16(16'h1C5A, 16'h002D);
    rd16(16'h1C00, 16'h103F);
    chk(pp_sel, 16'h0002, "pp reset");
    chk(sp1_sel, 16'h0001, "sp1 reset");
    chk(sp0_sel, 16'h0001, "sp0 reset");
    chk(reach, 16'h000F, "short reach");
    chk(gio_in, 16'h002D, "gpio input");
  endtask : t_boot

  task automatic t_straps;
    for (int s = 0; s < 4; s++)
    begin
      do_reset(s[1:0]);
      repeat (2) @(negedge i_clk);
      chk(reg_en, {15'h0000, ~s[0]}, "regulator");
      chk(reg_oe, {15'h0000, ~s[0]}, "reg output");
      chk(from_ext, {15'h0000, s[1]}, "clk source");
      chk(usb_osc, {15'h0000, ~s[1]}, "usb osc");
      chk(usb_ldo, {15'h0000, ~s[1]}, "usb ldo");
      osc_sw = 1'b1;
      ldo_sw = 1'b1;
      repeat (2) @(negedge i_clk);
      chk(usb_osc, 16'h0001, "usb osc sw");
      chk(usb_ldo, 16'h0001, "usb ldo sw");
      osc_sw = 1'b0;
      ldo_sw = 1'b0;
      pwr_ok = 1'b0;
      repeat (2) @(negedge i_clk);
      chk(int_rst_n, {15'h0000, s[0]}, "supply drop");
      chk(sg_eff, {15'h0000, s[0]}, "supply eff");
      pwr_ok = 1'b1;
      repeat (2) @(negedge i_clk);
      chk(int_rst_n, 16'h0001, "supply back");
    end
  endtask : t_straps

  task automatic t_routing;
    logic [2:0] c;
    logic [1:0] s0;
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      s0 = ~c[1:0];
      // affected peripherals count as gated and reset around each rewrite
      wr16(16'h1C00, {c[2], c, c[1:0], s0, 8'h3F});
      chk(pp_sel, c == 3'h7 ? 16'h0000 : 16'h0001 << c, "pp");
      chk(sp1_sel, c[1:0] == 2'h3 ? 16'h0000 : 16'h0001 << c[1:0],
          "sp1");
      chk(sp0_sel, 16'h0001 << s0, "sp0");
      chk(last_samp, {15'h0000, c[2] & (s0 == 2'h3)}, "clk pin");
    end
  endtask : t_routing

  task automatic t_addr;
    external_memory_interface_hi = 6'h15;
    gio_out = 6'h0A;
    gio_oe = 6'h05;
    wr16(16'h1C00, 16'h1000);
    @(negedge i_clk);
    chk(pin_oe, 16'h003F, "addr drive");
    chk(pin_out, 16'h0015, "addr out");
    chk(reach, 16'h0015, "full reach");
    chk(gio_in, 16'h0000, "gpio masked");
    gio_oe = 6'h02;
    wr16(16'h1C00, 16'h1007);
    @(negedge i_clk);
    chk(pin_oe, 16'h003A, "mixed drive");
    chk(pin_out, 16'h0012, "mixed out");
    chk(gio_in, 16'h0007, "mixed gpio");
    chk(reach, 16'h000F, "mixed reach");
  endtask : t_addr

  task automatic t_regs;
    wr16(16'h1C00, 16'hFFFF);
    rd16(16'h1C00, 16'hFF3F);
    wr16(16'h1C01, 16'h0000);
    rd16(16'h1C00, 16'hFF3F);
    rd16(16'h1C01, 16'h0000);
  endtask : t_regs

  // hang guard well above the expected run length
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      summarize;
    end
  end

  initial
  begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    osc_sw = 1'b0;
    ldo_sw = 1'b0;
    pwr_ok = 1'b1;
    addr = 16'h0000;
    wdata = 16'h0000;
    external_memory_interface_hi = 6'h00;
    gio_out = 6'h00;
    gio_oe = 6'h00;
    boot_term = 6'h00;
    strap_cfg = 2'h3;
    error_cnt = 0;
    num_checks = 0;
    cycles = 0;
    t_boot;
    t_straps;
    t_routing;
    t_addr;
    t_regs;
    summarize;
  end
endmodule : reset_config_and_bus_pin_mux_tb
